// File: gpcc_top.v
// gate pre-driver command block: decodes serial commands into six gate outputs
// and a load measurement multiplexer select
// assumes the internal pulse controller sits outside and supplies one pulse per channel
//
// Overview of operation
// - on/off bits 0..5 drive gate outputs one..six in order.
// - a one turns the gate on; a zero actively pulls it to ground.
// - bits 6..9 of the on/off word form the measurement select code.
// - a selected pair is released for measurement; other outputs run as set.
// - codes 0001..0110 select pairs one-two, three-four, five-six, each twice; odd codes put the lower on current source, even codes the upper.
// - codes 1010..1110 put sense two..six on current source, sense one on amplifier.
// - codes 0000, 0111, 1000, 1001, 1111 mean normal operation, no pair.
// - pin enable bits 0..5 gate input pins; zero enables, one disables.
// - after reset every pulse input pin is enabled.
// - a disabled pin ignores its combine bit; on/off bit or controller drives.
// - with pin enabled, combine bit zero ORs, one ANDs pin with on/off bit.
// - address bits 15..11 pick the command; bit ten is ignored.
// - bits 6..8 enable controller channels 1..3 (pin enable) and 4..6 (combine).
// - priority: measurement, then an enabled pin with combine one (AND with on/off bit, controller ignored), else on/off, controller or OR pin, else off.
// - reset turns outputs off, enables pins with OR, disables the controller.
// - in default mode outputs follow only their pins; registers are kept.
// - a 16-bit word framed by chip select acts at chip select rising.
`timescale 1ns/1ps
`include "gpcc_map.vh"

module gpcc_top (
    // clock and reset
    input wire clk,
    input wire arst_n,
    // serial command pins
    input wire sclk,
    input wire si,
    input wire cs_n,
    output wire so_out,
    output wire so_oe_n,
    // mode pin
    input wire default_mode,
    // pulse width input pins, bit n for pulse_input_pin_n
    input wire [5:0] pulse_input_pin_n,
    // pulses from the internal pulse controller, one per channel
    input wire [5:0] ctl_pulse,
    // gate outputs, bit n for gate_output_n
    output reg [5:0] gate_output_n_q,
    output reg [5:0] gate_pulldown_q,
    // measurement multiplexer: sense input to current source and to amplifier plus
    output reg [5:0] meas_to_source_q,
    output reg [5:0] meas_to_amp_q,
    // settings handed to the internal pulse controller
    output reg [5:0] ctl_enable_q,
    output reg [9:0] ch1_freq_duty_q
);
    reg [5:0] gate_on_q;
    reg [3:0] meas_sel_q;
    reg [5:0] pin_dis_q;
    reg [5:0] and_sel_q;
    reg [2:0] ctl_lo_q;
    reg [2:0] ctl_hi_q;
    reg [9:0] fd_q;
    reg [15:0] last_word_q;

    reg [1:0] dflt_s_q;

    wire word_valid;
    wire [15:0] word;
    wire [4:0] word_addr;
    wire [5:0] pin_now;
    wire [5:0] pulse_now;
    wire [5:0] drive_d;
    wire [5:0] pair_mask;
    wire [5:0] src_d;
    wire [5:0] amp_d;
    wire [5:0] pull_d;
    wire wr_gate;
    wire wr_pin_en;
    wire wr_combine;
    wire wr_fd;

    gpcc_spi_rx u_rx (
        .clk(clk),
        .arst_n(arst_n),
        .sclk(sclk),
        .si(si),
        .cs_n(cs_n),
        .so_q(so_out),
        .so_oe_n_q(so_oe_n),
        .resp_word(last_word_q),
        .word_valid_q(word_valid),
        .word_q(word)
    );

    // sense input routed to the current source for a select code, one-hot
    function [5:0] meas_source;
        input [3:0] code;
        begin
            case (code)
                4'h1: meas_source = 6'h01;
                4'h2: meas_source = 6'h02;
                4'h3: meas_source = 6'h04;
                4'h4: meas_source = 6'h08;
                4'h5: meas_source = 6'h10;
                4'h6: meas_source = 6'h20;
                4'ha: meas_source = 6'h02;
                4'hb: meas_source = 6'h04;
                4'hc: meas_source = 6'h08;
                4'hd: meas_source = 6'h10;
                4'he: meas_source = 6'h20;
                default: meas_source = 6'h00;
            endcase
        end
    endfunction

    // sense input routed to the amplifier plus input for a select code, one-hot
    function [5:0] meas_amp;
        input [3:0] code;
        begin
            case (code)
                4'h1: meas_amp = 6'h02;
                4'h2: meas_amp = 6'h01;
                4'h3: meas_amp = 6'h08;
                4'h4: meas_amp = 6'h04;
                4'h5: meas_amp = 6'h20;
                4'h6: meas_amp = 6'h10;
                4'ha: meas_amp = 6'h01;
                4'hb: meas_amp = 6'h01;
                4'hc: meas_amp = 6'h01;
                4'hd: meas_amp = 6'h01;
                4'he: meas_amp = 6'h01;
                default: meas_amp = 6'h00;
            endcase
        end
    endfunction

    // the released pair is exactly the two sense inputs in use
    assign src_d = meas_source(meas_sel_q);
    assign amp_d = meas_amp(meas_sel_q);
    assign pair_mask = src_d | amp_d;

    // bit ten sits between address and payload and is never looked at
    assign word_addr = word[`GPCC_ADDR_HI:`GPCC_ADDR_LO];

    // address match against one command code
    function addr_hit;
        input [4:0] addr;
        input [4:0] code;
        begin
            addr_hit = (addr == code);
        end
    endfunction

    // one strobe per command register; an unknown address raises none of them
    assign wr_gate = word_valid & addr_hit(word_addr, `GPCC_ADDR_GATE);
    assign wr_pin_en = word_valid & addr_hit(word_addr, `GPCC_ADDR_PIN_EN);
    assign wr_combine = word_valid & addr_hit(word_addr, `GPCC_ADDR_COMBINE);
    assign wr_fd = word_valid & addr_hit(word_addr, `GPCC_ADDR_CH1_FD);

    // any accepted word, whatever its address, becomes the next echo
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            last_word_q <= `GPCC_RST_WORD;
        end else if (word_valid) begin
            last_word_q <= word;
        end
    end

    // registers are kept in default mode; only the outputs change source
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            gate_on_q <= `GPCC_RST_GATE;
            meas_sel_q <= `GPCC_RST_MEAS;
        end else if (wr_gate) begin
            gate_on_q <= word[`GPCC_GATE_HI:`GPCC_GATE_LO];
            meas_sel_q <= word[`GPCC_MEAS_HI:`GPCC_MEAS_LO];
        end
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pin_dis_q <= `GPCC_RST_PIN_DIS;
            ctl_lo_q <= `GPCC_RST_CTL;
        end else if (wr_pin_en) begin
            pin_dis_q <= word[`GPCC_GATE_HI:`GPCC_GATE_LO];
            ctl_lo_q <= word[`GPCC_CTL_HI:`GPCC_CTL_LO];
        end
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            and_sel_q <= `GPCC_RST_AND;
            ctl_hi_q <= `GPCC_RST_CTL;
        end else if (wr_combine) begin
            and_sel_q <= word[`GPCC_GATE_HI:`GPCC_GATE_LO];
            ctl_hi_q <= word[`GPCC_CTL_HI:`GPCC_CTL_LO];
        end
    end

    // frequency and duty coding is out of scope here; the field is only handed on
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            fd_q <= `GPCC_RST_FD;
        end else if (wr_fd) begin
            fd_q <= word[`GPCC_FD_HI:`GPCC_FD_LO];
        end
    end

    // mode pin is asynchronous to clk
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            dflt_s_q <= 2'h0;
        end else begin
            dflt_s_q <= {dflt_s_q[0], default_mode};
        end
    end

    // per-output resolve: {drive, pull to ground}; both low releases the output
    function [1:0] gate_resolve;
        input in_pair;
        input dflt;
        input pin_used;
        input and_sel;
        input on_bit;
        input pin;
        input ctl_on;
        reg drive_on;
        begin
            drive_on = 1'b0;
            if (dflt) begin
                drive_on = pin;
            end else if (pin_used && and_sel) begin
                // an AND with a low pin holds the output off even against the on/off bit
                drive_on = on_bit & pin;
            end else if (pin_used) begin
                drive_on = on_bit | pin | ctl_on;
            end else begin
                drive_on = on_bit | ctl_on;
            end
            if (in_pair && !dflt) begin
                // released pair: neither driven nor pulled down
                gate_resolve = 2'b00;
            end else begin
                gate_resolve = {drive_on, ~drive_on};
            end
        end
    endfunction

    genvar i;
    generate
        // pins and controller pulses may change at any moment, so both are synchronised
        for (i = 0; i < 6; i = i + 1) begin : g_sync
            reg [1:0] pin_s_q;
            reg [1:0] ctl_s_q;

            always @(posedge clk or negedge arst_n) begin
                if (!arst_n) begin
                    pin_s_q <= 2'h0;
                    ctl_s_q <= 2'h0;
                end else begin
                    pin_s_q <= {pin_s_q[0], pulse_input_pin_n[i]};
                    ctl_s_q <= {ctl_s_q[0], ctl_pulse[i]};
                end
            end

            assign pin_now[i] = pin_s_q[1];
            assign pulse_now[i] = ctl_s_q[1];
        end

        for (i = 0; i < 6; i = i + 1) begin : g_ch
            wire ctl_on;

            assign ctl_on = ctl_enable_q[i] & pulse_now[i];
            assign {drive_d[i], pull_d[i]} = gate_resolve(pair_mask[i], dflt_s_q[1],
                ~pin_dis_q[i], and_sel_q[i], gate_on_q[i], pin_now[i], ctl_on);
        end
    endgenerate

    // settings for the pulse controller follow the registers one clock later
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ctl_enable_q <= 6'h00;
            ch1_freq_duty_q <= `GPCC_RST_FD;
        end else begin
            ctl_enable_q <= {ctl_hi_q, ctl_lo_q};
            ch1_freq_duty_q <= fd_q;
        end
    end

    // outputs are registered so the gate pins never see decode glitches
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            gate_output_n_q <= 6'h00;
            gate_pulldown_q <= 6'h3f;
            meas_to_source_q <= 6'h00;
            meas_to_amp_q <= 6'h00;
        end else begin
            gate_output_n_q <= drive_d;
            gate_pulldown_q <= pull_d;
            if (dflt_s_q[1]) begin
                // default mode leaves measurement idle; pins alone drive the gates
                meas_to_source_q <= 6'h00;
                meas_to_amp_q <= 6'h00;
            end else begin
                meas_to_source_q <= src_d;
                meas_to_amp_q <= amp_d;
            end
        end
    end
endmodule

// File: gpcc_map.vh
// offsets, field positions, reset values and frame bit counts of the gate pre-driver command block
// assumes 16-bit command words, address in the top five bits
`ifndef GPCC_MAP_VH
`define GPCC_MAP_VH

`define GPCC_WORD_W 16
`define GPCC_ADDR_HI 15
`define GPCC_ADDR_LO 11
`define GPCC_ADDR_GATE 5'h09
`define GPCC_ADDR_PIN_EN 5'h0a
`define GPCC_ADDR_COMBINE 5'h0b
`define GPCC_ADDR_CH1_FD 5'h0c

`define GPCC_GATE_LO 0
`define GPCC_GATE_HI 5
`define GPCC_MEAS_LO 6
`define GPCC_MEAS_HI 9
`define GPCC_CTL_LO 6
`define GPCC_CTL_HI 8
`define GPCC_FD_LO 0
`define GPCC_FD_HI 9

`define GPCC_RST_GATE 6'h00
`define GPCC_RST_MEAS 4'h0
`define GPCC_RST_PIN_DIS 6'h00
`define GPCC_RST_AND 6'h00
`define GPCC_RST_CTL 3'h0
`define GPCC_RST_FD 10'h000
`define GPCC_RST_WORD 16'h0000

`define GPCC_MIN_BITS 8'h10
`define GPCC_BIT_CNT_W 8
`define GPCC_BIT_CNT_MAX 8'hff

`endif

// File: gpcc_spi_rx.v
// serial frame receiver: shifts command bits in, echoes bits out, checks the clock count
// assumes sclk, si and cs_n are asynchronous pins and sclk is well below clk/4
`timescale 1ns/1ps
`include "gpcc_map.vh"

module gpcc_spi_rx (
    // clock and reset
    input wire clk,
    input wire arst_n,
    // serial pins
    input wire sclk,
    input wire si,
    input wire cs_n,
    output reg so_q,
    output reg so_oe_n_q,
    // word loaded into the shifter at the start of a frame
    input wire [15:0] resp_word,
    // accepted command word
    output reg word_valid_q,
    output reg [15:0] word_q
);
    localparam ST_IDLE = 2'b01;
    localparam ST_SHIFT = 2'b10;

    reg [2:0] sclk_s_q;
    reg [1:0] si_s_q;
    reg [2:0] cs_s_q;
    reg [1:0] state_q;
    reg [15:0] sh_q;
    reg [7:0] cnt_q;
    wire sclk_rise;
    wire sclk_fall;
    wire cs_fall;
    wire cs_rise;
    wire frame_ok;

    assign sclk_rise = sclk_s_q[1] & ~sclk_s_q[2];
    assign sclk_fall = ~sclk_s_q[1] & sclk_s_q[2];
    assign cs_fall = ~cs_s_q[1] & cs_s_q[2];
    assign cs_rise = cs_s_q[1] & ~cs_s_q[2];
    // 16 clocks plus any multiple of 8; a saturated count is never a multiple of 8
    assign frame_ok = (cnt_q >= `GPCC_MIN_BITS) && (cnt_q[2:0] == 3'h0);

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sclk_s_q <= 3'h0;
            si_s_q <= 2'h0;
            cs_s_q <= 3'h7;
        end else begin
            sclk_s_q <= {sclk_s_q[1:0], sclk};
            si_s_q <= {si_s_q[0], si};
            cs_s_q <= {cs_s_q[1:0], cs_n};
        end
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= ST_IDLE;
            sh_q <= `GPCC_RST_WORD;
            cnt_q <= 8'h00;
            so_q <= 1'b0;
            so_oe_n_q <= 1'b1;
            word_valid_q <= 1'b0;
            word_q <= `GPCC_RST_WORD;
        end else begin
            word_valid_q <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    if (cs_fall) begin
                        state_q <= ST_SHIFT;
                        sh_q <= resp_word;
                        so_q <= resp_word[15];
                        so_oe_n_q <= 1'b0;
                        cnt_q <= 8'h00;
                    end
                end
                ST_SHIFT: begin
                    if (cs_rise) begin
                        // the word acts only when chip select rises
                        state_q <= ST_IDLE;
                        so_oe_n_q <= 1'b1;
                        if (frame_ok) begin
                            word_valid_q <= 1'b1;
                            word_q <= sh_q;
                        end
                    end else if (sclk_rise) begin
                        sh_q <= {sh_q[14:0], si_s_q[1]};
                        if (cnt_q != `GPCC_BIT_CNT_MAX) begin
                            cnt_q <= cnt_q + 8'h01;
                        end
                    end else if (sclk_fall) begin
                        so_q <= sh_q[15];
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                    so_oe_n_q <= 1'b1;
                end
            endcase
        end
    end
endmodule

// File: gpcc_top_properties.sv
// concurrent checks on the ports of the gate pre-driver command block
// assumes one clock domain and frames spaced well apart by the serial master
`timescale 1ns/1ps
module gpcc_checker (
    // clock and reset
    input wire clk,
    input wire arst_n,
    // serial pins
    input wire sclk,
    input wire si,
    input wire cs_n,
    input wire so_out,
    input wire so_oe_n,
    // mode and pulse inputs
    input wire default_mode,
    input wire [5:0] pulse_input_pin_n,
    input wire [5:0] ctl_pulse,
    // block outputs
    input wire [5:0] gate_output_n_q,
    input wire [5:0] gate_pulldown_q,
    input wire [5:0] meas_to_source_q,
    input wire [5:0] meas_to_amp_q,
    input wire [5:0] ctl_enable_q,
    input wire [9:0] ch1_freq_duty_q
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    a_reset_all_off: assert property ($rose(arst_n) |-> ctl_enable_q == 6'h00 && gate_output_n_q == 6'h00)
        else $error("controller enable or gate set just after reset");
    a_drive_pull_excl: assert property ((gate_output_n_q & gate_pulldown_q) == 6'h00)
        else $error("gate driven and pulled down together");
    a_pull_when_off: assert property ((meas_to_source_q | meas_to_amp_q) == 6'h00 |-> gate_pulldown_q == ~gate_output_n_q)
        else $error("gate neither driven nor pulled down outside measurement");
    a_meas_pair_released: assert property (((meas_to_source_q | meas_to_amp_q) & (gate_output_n_q | gate_pulldown_q)) == 6'h00)
        else $error("measured output still driven");
    a_meas_one_pair: assert property ($onehot0(meas_to_source_q) && $onehot0(meas_to_amp_q) && (meas_to_source_q & meas_to_amp_q) == 6'h00 && ((meas_to_source_q == 6'h00) == (meas_to_amp_q == 6'h00)))
        else $error("measurement routing not one pair");
    a_default_follow: assert property (default_mode [*6] |-> gate_output_n_q == $past(pulse_input_pin_n, 3) && meas_to_source_q == 6'h00)
        else $error("default mode output not following pins");
    a_cfg_frame_stable: assert property (!cs_n [*8] |-> $stable(ctl_enable_q) && $stable(ch1_freq_duty_q))
        else $error("settings changed inside a frame");
    a_so_enable_frame: assert property ((!cs_n [*4] |-> !so_oe_n) and (cs_n [*4] |-> so_oe_n))
        else $error("serial out enable does not follow frame");
endmodule

bind gpcc_top gpcc_checker u_gpcc_checker (
    .clk, .arst_n, .sclk, .si, .cs_n, .so_out, .so_oe_n, .default_mode,
    .pulse_input_pin_n, .ctl_pulse, .gate_output_n_q, .gate_pulldown_q,
    .meas_to_source_q, .meas_to_amp_q, .ctl_enable_q, .ch1_freq_duty_q
);

// File: gpcc_mcu_model.sv
// serial master standing in for the microcontroller
// assumes clk at 50 ns; sclk halves of 4 clk stay well inside the block's sampling limit
`timescale 1ns/1ps
module gpcc_mcu_model (
    // clock
    input wire clk,
    // serial pins toward the block
    output logic sclk,
    output logic si,
    output logic cs_n,
    // serial data back from the block
    input wire so_out
);
    // bits seen on the return line, sampled just before each rising sclk
    logic [31:0] rx;

    initial begin
        rx = 32'h00000000;
        sclk = 1'b0;
        si = 1'b0;
        cs_n = 1'b1;
    end
    // sends bits n-1..0 of w, msb first; sclk idles low between frames
    task automatic send(input logic [31:0] w, input int n);
        int i;
        @(negedge clk);
        cs_n = 1'b0;
        repeat (4) @(negedge clk);
        for (i = n - 1; i >= 0; i--) begin
            si = w[i];
            repeat (4) @(negedge clk);
            rx = {rx[30:0], so_out};
            sclk = 1'b1;
            repeat (4) @(negedge clk);
            sclk = 1'b0;
        end
        repeat (4) @(negedge clk);
        cs_n = 1'b1;
        // released line must not keep showing the last bit
        si = ~si;
        repeat (10) @(negedge clk);
    endtask
endmodule

// File: gpcc_top_tb_top.sv
// self-checking bench for the gate pre-driver command block
// assumes the serial master model and the bound port checker
`timescale 1ns/1ps
module gpcc_top_tb_top;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic default_mode = 1'b0;
    logic [5:0] pins = 6'h00;
    logic [5:0] ctl_pulse = 6'h00;
    wire sclk, si, cs_n, so_out, so_oe_n;
    wire [5:0] gate, pull, src, amp, ctl_en;
    wire [9:0] fd;
    int fails = 0;
    int n_compared = 0;

    always #25 clk = ~clk;

    gpcc_mcu_model u_gpcc_mcu_model (.clk(clk), .sclk(sclk), .si(si), .cs_n(cs_n),
        .so_out(so_out));
    gpcc_top u_gpcc_top (.clk(clk), .arst_n(arst_n), .sclk(sclk), .si(si), .cs_n(cs_n),
        .so_out(so_out), .so_oe_n(so_oe_n), .default_mode(default_mode),
        .pulse_input_pin_n(pins), .ctl_pulse(ctl_pulse), .gate_output_n_q(gate),
        .gate_pulldown_q(pull), .meas_to_source_q(src), .meas_to_amp_q(amp),
        .ctl_enable_q(ctl_en), .ch1_freq_duty_q(fd));

    task automatic end_sim;
        if (fails == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cmd(input logic [4:0] a, input logic [9:0] d);
        u_gpcc_mcu_model.send({16'h0000, a, 1'b0, d}, 16);
    endtask

    task automatic t_reset;
        chk(gate, 6'h00);
        chk(pull, 6'h3f);
        chk({src, amp}, 12'h000);
        chk(ctl_en, 6'h00);
        chk(so_oe_n, 1'b1);
        pins = 6'h2a;
        repeat (5) @(negedge clk);
        chk(gate, 6'h2a);
        pins = 6'h00;
        repeat (5) @(negedge clk);
    endtask

    task automatic t_gate;
        int i;
        for (i = 0; i < 6; i++) begin
            cmd(5'h09, 10'h001 << i);
            if (i > 0) chk(u_gpcc_mcu_model.rx[15:0], {5'h09, 1'b0, 10'h001 << (i - 1)});
            chk(gate, 6'h01 << i);
            chk(pull, 6'h3f ^ (6'h01 << i));
        end
    endtask

    task automatic t_meas;
        int c;
        logic [5:0] s, a;
        for (c = 0; c < 16; c++) begin
            s = 6'h00;
            a = 6'h00;
            if (c >= 1 && c <= 6) begin
                s = 6'h01 << (c - 1);
                a = 6'h01 << ((c - 1) ^ 1);
            end
            if (c >= 10 && c <= 14) begin
                s = 6'h01 << (c - 9);
                a = 6'h01;
            end
            u_gpcc_mcu_model.send({16'h0000, 5'h09, c[0], c[3:0], 6'h15}, 16);
            chk(src, s);
            chk(amp, a);
            chk(gate, 6'h15 & ~(s | a));
            chk(pull, 6'h2a & ~(s | a));
        end
    endtask

    task automatic t_pins;
        cmd(5'h09, 10'h000);
        cmd(5'h0a, 10'h17f);
        pins = 6'h3f;
        repeat (5) @(negedge clk);
        chk(gate, 6'h00);
        chk(ctl_en, 6'h05);
        ctl_pulse = 6'h3f;
        repeat (5) @(negedge clk);
        chk(gate, 6'h05);
        ctl_pulse = 6'h00;
        cmd(5'h0a, 10'h000);
        cmd(5'h0b, 10'h0cf);
        chk(ctl_en, 6'h18);
        chk(gate, 6'h30);
        cmd(5'h09, 10'h003);
        chk(gate, 6'h33);
        pins = 6'h00;
        cmd(5'h0b, 10'h000);
        chk(gate, 6'h03);
    endtask

    task automatic t_refused;
        u_gpcc_mcu_model.send(32'h0000483f, 15);
        u_gpcc_mcu_model.send(32'h0000483f, 17);
        u_gpcc_mcu_model.send(32'h0000f83f, 16);
        chk(gate, 6'h03);
        u_gpcc_mcu_model.send(32'h00ff6155, 24);
        chk(fd, 10'h155);
        chk({ctl_en, gate}, 12'h003);
    endtask

    task automatic t_default;
        default_mode = 1'b1;
        pins = 6'h2c;
        repeat (8) @(negedge clk);
        chk(gate, 6'h2c);
        default_mode = 1'b0;
        pins = 6'h00;
        repeat (8) @(negedge clk);
        chk(gate, 6'h03);
    endtask

    initial begin
        repeat (6) @(negedge clk);
        arst_n = 1'b1;
        repeat (4) @(negedge clk);
        t_reset;
        t_gate;
        t_meas;
        t_pins;
        t_refused;
        t_default;
        end_sim;
    end

    initial begin
        repeat (100000) @(posedge clk);
        fails++;
        end_sim;
    end
endmodule
